/* usbp_defs.vh */
// Behaviour
// - Port reads enabled when enabled=1,suspend=0; suspended when both are 1.
// - While suspended, downstream data traffic is blocked except port reset signalling.
// - A transaction under way when suspend is set finishes before blocking starts.
// - Suspend bit reads 1 only once the port is really suspended.
// - While suspended, port lines are watched for resume from the device.
// - Software writes of 0 to the suspend bit are ignored.
// - Suspend clears when software drops force-resume or sets port reset.
// - Full-speed K is driven until software writes force-resume to 0.
// - J-to-K while suspended sets force-resume and port-change-detect, status bit 2.
// - Software setting force-resume leaves port-change-detect unchanged.
// - After clearing, port returns to HS idle; bit reads 1 until done, within 2 ms.
// - Overcurrent-change, bit 5, sets whenever overcurrent-active changes.
// - Overcurrent-change clears on software write of 1.
// - Overcurrent-active, bit 4, follows the overcurrent condition.
// - Reset clears suspend, force-resume, overcurrent-change and overcurrent-active.
// - Power-dependent status fields read 0 while port power is 0.
// - Only the hardware enable sequence sets the enabled bit; software 1 ignored.
`ifndef USBP_DEFS_VH
`define USBP_DEFS_VH

// Register byte addresses
`define USBP_ADDR_PORT     4'h0
`define USBP_ADDR_STATUS   4'h4

// Port register fields
`define USBP_BIT_PED       2
`define USBP_BIT_OCA       4
`define USBP_BIT_OCC       5
`define USBP_BIT_FPR       6
`define USBP_BIT_PORT_SUSPEND_BIT      7
`define USBP_BIT_PR        8
`define USBP_BIT_PP        12

// Status register fields
`define USBP_BIT_PCD       2

// Reset values
`define USBP_RST_PP        1'b0
`define USBP_RST_BIT       1'b0

// Resume exit time: 2 ms at 100 MHz
`define USBP_EXIT_MS       2
`define USBP_CLK_KHZ       100000
`define USBP_EXIT_CYC      (`USBP_EXIT_MS * `USBP_CLK_KHZ)

`endif

/* usbp_sync.v */
`timescale 1ns/1ps
module usbp_sync (
  clk,
  resetn,
  din,
  dout
);
  input  wire clk;
  input  wire resetn;
  input  wire din;
  output wire dout;

  reg meta_r;
  reg sync_r;

  // Two-flop synchroniser
  always @(posedge clk) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule // usbp_sync

/* usbp_port.v */
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "usbp_defs.vh"
module usbp_port #(
  parameter EXIT_CYC = `USBP_EXIT_CYC,
  parameter CNT_W    = 18
) (
  clk,
  resetn,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  txn_active,
  line_j,
  line_k,
  enable_grant,
  port_fault,
  oc_in,
  hs_idle_ack,
  drive_k,
  hs_idle_drive,
  traffic_block,
  port_power,
  port_reset
);
  input  wire        clk;
  input  wire        resetn;
  input  wire [3:0]  avs_address;
  input  wire        avs_read;
  input  wire        avs_write;
  input  wire [31:0] avs_writedata;
  input  wire [3:0]  avs_byteenable;
  output reg  [31:0] avs_readdata;
  output reg         avs_waitrequest;
  input  wire        txn_active;
  input  wire        line_j;
  input  wire        line_k;
  input  wire        enable_grant;
  input  wire        port_fault;
  input  wire        oc_in;
  input  wire        hs_idle_ack;
  output reg         drive_k;
  output reg         hs_idle_drive;
  output reg         traffic_block;
  output reg         port_power;
  output reg         port_reset;

  localparam [1:0] RS_IDLE  = 2'b00;
  localparam [1:0] RS_DRIVE = 2'b01;
  localparam [1:0] RS_EXIT  = 2'b10;

  localparam integer     EXIT_LAST_I = EXIT_CYC - 1;
  localparam [CNT_W-1:0] EXIT_LAST   = EXIT_LAST_I[CNT_W-1:0];

  reg              ped_r;
  reg              ped_nxt;
  reg              port_suspend_bit_r;
  reg              port_suspend_bit_nxt;
  reg              sreq_r;
  reg              sreq_nxt;
  reg              pr_r;
  reg              pr_nxt;
  reg              pp_r;
  reg              pp_nxt;
  reg              occ_r;
  reg              occ_nxt;
  reg              oca_r;
  reg              pcd_r;
  reg              pcd_nxt;
  reg  [1:0]       rs_r;
  reg  [1:0]       rs_nxt;
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  reg              prev_j_r;
  reg  [31:0]      rd_nxt;
  wire             oc_sync;
  wire             req;
  wire             take;
  wire             done;
  wire             wr_port;
  wire             wr_stat;
  wire             lane0;
  wire             lane1;
  wire             wr_lo;
  wire             wr_hi;
  wire             fpr_rd;
  wire             jk_evt;

  // Synchronised overcurrent input
  usbp_sync u_oc_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (oc_in),
    .dout   (oc_sync)
  );

  function lane_on;
    input [3:0] be;
    input integer idx;
    begin
      lane_on = be[idx];
    end
  endfunction

  function pw_gate;
    input pwr;
    input val;
    begin
      pw_gate = pwr & val;
    end
  endfunction

  // Bus decode
  assign req     = avs_read | avs_write;
  assign take    = req & avs_waitrequest;
  assign done    = req & !avs_waitrequest;
  assign wr_port = done & avs_write & (avs_address == `USBP_ADDR_PORT);
  assign wr_stat = done & avs_write & (avs_address == `USBP_ADDR_STATUS);
  assign lane0   = lane_on(avs_byteenable, 0);
  assign lane1   = lane_on(avs_byteenable, 1);
  assign wr_lo   = wr_port & lane0;
  assign wr_hi   = wr_port & lane1;
  assign fpr_rd  = (rs_r != RS_IDLE);
  // Resume detect while suspended
  assign jk_evt  = port_suspend_bit_r & (rs_r == RS_IDLE) & prev_j_r & line_k;

  always @* begin
    ped_nxt  = ped_r;
    port_suspend_bit_nxt = port_suspend_bit_r;
    sreq_nxt = sreq_r;
    pr_nxt   = pr_r;
    pp_nxt   = pp_r;
    occ_nxt  = occ_r;
    pcd_nxt  = pcd_r;
    rs_nxt   = rs_r;
    cnt_nxt  = cnt_r;

    // Port enable from hardware sequence only
    if (enable_grant & pr_r) begin
      ped_nxt = 1'b1;
    end
    if (port_fault) begin
      ped_nxt = 1'b0;
    end

    // Software writes to the port register
    if (wr_lo) begin
      if (!avs_writedata[`USBP_BIT_PED]) begin
        ped_nxt = 1'b0;
      end
      if (avs_writedata[`USBP_BIT_PORT_SUSPEND_BIT] & ped_r & !port_suspend_bit_r) begin
        sreq_nxt = 1'b1;
      end
      if (avs_writedata[`USBP_BIT_OCC]) begin
        occ_nxt = 1'b0;
      end
    end
    if (wr_hi) begin
      pp_nxt = avs_writedata[`USBP_BIT_PP];
      pr_nxt = avs_writedata[`USBP_BIT_PR];
    end

    // Suspend entry waits for the current transaction
    if (sreq_r & !txn_active) begin
      port_suspend_bit_nxt = 1'b1;
      sreq_nxt = 1'b0;
    end

    // Resume sequencer
    case (rs_r)
      RS_IDLE: begin
        if (jk_evt) begin
          rs_nxt = RS_DRIVE;
        end else if (wr_lo & avs_writedata[`USBP_BIT_FPR]) begin
          rs_nxt = RS_DRIVE;
        end
      end
      RS_DRIVE: begin
        if (wr_lo & !avs_writedata[`USBP_BIT_FPR]) begin
          rs_nxt   = RS_EXIT;
          cnt_nxt  = {CNT_W{1'b0}};
          port_suspend_bit_nxt = 1'b0;
          sreq_nxt = 1'b0;
        end
      end
      RS_EXIT: begin
        cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        if (hs_idle_ack | (cnt_r == EXIT_LAST)) begin
          rs_nxt  = RS_IDLE;
          cnt_nxt = {CNT_W{1'b0}};
        end
      end
      default: begin
        rs_nxt  = RS_IDLE;
        cnt_nxt = {CNT_W{1'b0}};
      end
    endcase

    // Port reset start clears suspend
    if (wr_hi & avs_writedata[`USBP_BIT_PR] & !pr_r) begin
      port_suspend_bit_nxt = 1'b0;
      sreq_nxt = 1'b0;
    end

    // Device resume flag, set wins over clear
    if (jk_evt) begin
      pcd_nxt = 1'b1;
    end else if (wr_stat & lane0 & avs_writedata[`USBP_BIT_PCD]) begin
      pcd_nxt = 1'b0;
    end

    // Overcurrent change, set wins over clear
    if (oc_sync != oca_r) begin
      occ_nxt = 1'b1;
    end
  end

  // Read data with power gating
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (avs_address)
      `USBP_ADDR_PORT: begin
        rd_nxt[`USBP_BIT_PP]   = pp_r;
        rd_nxt[`USBP_BIT_PR]   = pw_gate(pp_r, pr_r);
        rd_nxt[`USBP_BIT_PORT_SUSPEND_BIT] = pw_gate(pp_r, port_suspend_bit_r);
        rd_nxt[`USBP_BIT_FPR]  = pw_gate(pp_r, fpr_rd);
        rd_nxt[`USBP_BIT_OCC]  = pw_gate(pp_r, occ_r);
        rd_nxt[`USBP_BIT_OCA]  = pw_gate(pp_r, oca_r);
        rd_nxt[`USBP_BIT_PED]  = pw_gate(pp_r, ped_r);
      end
      `USBP_ADDR_STATUS: begin
        rd_nxt[`USBP_BIT_PCD]  = pcd_r;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // State registers
  always @(posedge clk) begin
    if (!resetn) begin
      ped_r    <= `USBP_RST_BIT;
      port_suspend_bit_r   <= `USBP_RST_BIT;
      sreq_r   <= 1'b0;
      pr_r     <= `USBP_RST_BIT;
      pp_r     <= `USBP_RST_PP;
      occ_r    <= `USBP_RST_BIT;
      oca_r    <= `USBP_RST_BIT;
      pcd_r    <= `USBP_RST_BIT;
      rs_r     <= RS_IDLE;
      cnt_r    <= {CNT_W{1'b0}};
      prev_j_r <= 1'b0;
    end else begin
      ped_r    <= ped_nxt;
      port_suspend_bit_r   <= port_suspend_bit_nxt;
      sreq_r   <= sreq_nxt;
      pr_r     <= pr_nxt;
      pp_r     <= pp_nxt;
      occ_r    <= occ_nxt;
      oca_r    <= oc_sync;
      pcd_r    <= pcd_nxt;
      rs_r     <= rs_nxt;
      cnt_r    <= cnt_nxt;
      prev_j_r <= line_j & !line_k;
    end
  end

  // Avalon slave, one wait state per access
  always @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (take) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_nxt : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Link-facing outputs
  always @(posedge clk) begin
    if (!resetn) begin
      drive_k       <= 1'b0;
      hs_idle_drive <= 1'b0;
      traffic_block <= 1'b0;
      port_power    <= `USBP_RST_PP;
      port_reset    <= 1'b0;
    end else begin
      drive_k       <= (rs_nxt == RS_DRIVE);
      hs_idle_drive <= (rs_nxt == RS_EXIT);
      traffic_block <= port_suspend_bit_nxt & !pr_nxt;
      port_power    <= pp_nxt;
      port_reset    <= pr_nxt;
    end
  end
endmodule // usbp_port

/* usbp_monitor.sv */
`timescale 1ns/1ps
module usbp_monitor #(
  parameter EXIT_CYC = 20
) (
  input wire        clk,
  input wire        resetn,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        txn_active,
  input wire        drive_k,
  input wire        hs_idle_drive,
  input wire        traffic_block,
  input wire        port_power,
  input wire        port_reset
);
  reg [31:0] exit_cnt_r;
  always @(posedge clk) begin
    if (!resetn || !hs_idle_drive) exit_cnt_r <= 32'h0;
    else exit_cnt_r <= exit_cnt_r + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ACK_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  AST_ACK_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  AST_RST_QUIET: assert property ($rose(resetn) |-> !drive_k && !hs_idle_drive && !traffic_block)
    else $error("busy after reset");
  AST_BLK_RESET: assert property (port_reset |-> !traffic_block) else $error("reset blocked");
  AST_BLK_TXN: assert property ($rose(traffic_block) |-> !$past(txn_active)) else $error("cut txn");
  AST_K_EXCL: assert property (drive_k |-> !hs_idle_drive) else $error("k and idle");
  AST_EXIT_FOLLOW: assert property ($fell(drive_k) && !port_reset |-> hs_idle_drive)
    else $error("no exit");
  AST_EXIT_BOUND: assert property (exit_cnt_r <= EXIT_CYC) else $error("exit too long");
  AST_PWR_READ: assert property (!avs_waitrequest && avs_read && avs_address == 4'h0 && !port_power
    |-> avs_readdata[8:4] == 5'h0 && !avs_readdata[2]) else $error("unpowered bits");
endmodule // usbp_monitor
bind usbp_port usbp_monitor #(.EXIT_CYC(EXIT_CYC)) mon (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .txn_active(txn_active), .drive_k(drive_k),
  .hs_idle_drive(hs_idle_drive), .traffic_block(traffic_block), .port_power(port_power),
  .port_reset(port_reset));

/* usbp_dev.sv */
`timescale 1ns/1ps
module usbp_dev (
  input  wire clk,
  input  wire wake,
  input  wire hs_idle_drive,
  output wire line_j,
  output wire line_k,
  output wire hs_idle_ack
);
  reg [3:0] cnt_r;
  assign line_k = wake;
  assign line_j = !wake;
  assign hs_idle_ack = cnt_r == 4'h8;
  always @(posedge clk) begin
    cnt_r <= hs_idle_drive ? cnt_r + 4'h1 : 4'h0;
  end
endmodule // usbp_dev

/* tb.sv */
`timescale 1ns/1ps
module tb;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg         rd_en = 1'b0;
  reg         wr_en = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg         txn = 1'b0;
  reg         oc = 1'b0;
  reg         wake = 1'b0;
  reg         grant = 1'b0;
  reg  [31:0] q;
  wire [31:0] rdat;
  wire        wreq, lj, lk, ack, dk, hsd, blk, pwr, prst;
  integer     err_count = 0;
  integer     n_compared = 0;
  always #5 clk = ~clk;
  usbp_port #(.EXIT_CYC(20)) DUT (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .txn_active(txn), .line_j(lj), .line_k(lk), .enable_grant(grant),
    .port_fault(1'b0), .oc_in(oc), .hs_idle_ack(ack), .drive_k(dk), .hs_idle_drive(hsd),
    .traffic_block(blk), .port_power(pwr), .port_reset(prst));
  usbp_dev dev (.clk(clk), .wake(wake), .hs_idle_drive(hsd), .line_j(lj), .line_k(lk), .hs_idle_ack(ack));
  task report_and_stop;
    begin
      $display("Compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] d);
    begin
      adr <= a;
      wd <= d;
      wr_en <= w;
      rd_en <= !w;
      do begin
        @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [31:0] exp);
    begin
      acc(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask
  initial begin
    #50000;
    err_count = err_count + 1;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(4'h0, 32'h0);
    acc(1'b1, 4'h0, 32'h1004);
    rd(4'h0, 32'h1000);
    acc(1'b1, 4'h0, 32'h1100);
    grant <= 1'b1;
    @(posedge clk);
    grant <= 1'b0;
    acc(1'b1, 4'h0, 32'h1004);
    rd(4'h0, 32'h1004);
    txn <= 1'b1;
    acc(1'b1, 4'h0, 32'h1084);
    rd(4'h0, 32'h1004);
    chk(blk, 32'h0);
    txn <= 1'b0;
    repeat (3) @(posedge clk);
    rd(4'h0, 32'h1084);
    chk(blk, 32'h1);
    acc(1'b1, 4'h0, 32'h1004);
    rd(4'h0, 32'h1084);
    wake <= 1'b1;
    repeat (3) @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(posedge clk);
    rd(4'h0, 32'h10c4);
    chk(dk, 32'h1);
    rd(4'h4, 32'h4);
    acc(1'b1, 4'h4, 32'h4);
    rd(4'h4, 32'h0);
    acc(1'b1, 4'h0, 32'h1004);
    chk(hsd, 32'h1);
    rd(4'h0, 32'h1044);
    repeat (12) @(posedge clk);
    rd(4'h0, 32'h1004);
    acc(1'b1, 4'h0, 32'h1044);
    chk(dk, 32'h1);
    rd(4'h4, 32'h0);
    acc(1'b1, 4'h0, 32'h1004);
    repeat (12) @(posedge clk);
    oc <= 1'b1;
    repeat (5) @(posedge clk);
    rd(4'h0, 32'h1034);
    acc(1'b1, 4'h0, 32'h1024);
    rd(4'h0, 32'h1014);
    oc <= 1'b0;
    repeat (5) @(posedge clk);
    rd(4'h0, 32'h1024);
    acc(1'b1, 4'h0, 32'h1084);
    repeat (3) @(posedge clk);
    acc(1'b1, 4'h0, 32'h1104);
    chk(prst, 32'h1);
    rd(4'h0, 32'h1124);
    chk(blk, 32'h0);
    oc <= 1'b1;
    repeat (5) @(posedge clk);
    acc(1'b1, 4'h0, 32'h0);
    chk(pwr, 32'h0);
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    report_and_stop;
  end
endmodule // tb
